// *** include/lsce_defines.svh ***
`ifndef LSCE_DEFINES_SVH
`define LSCE_DEFINES_SVH

// register indices, byte address is four times the index
`define LSCE_IDX_W        10
`define LSCE_IDX_STATUS   10'h208
`define LSCE_IDX_CHAN     10'h209
`define LSCE_IDX_SYNCW    10'h20f
`define LSCE_IDX_MASK     10'h300
`define LSCE_IDX_CTRL     10'h301
`define LSCE_IDX_GEOM     10'h302
`define LSCE_IDX_NONE     10'h3ff

// address slicing
`define LSCE_IDX_HI       11
`define LSCE_IDX_LO       2
`define LSCE_ADDR_TOP     31
`define LSCE_ADDR_TOPLO   12

// status bit positions
`define LSCE_ST_LINK      6
`define LSCE_ST_SYNC      5
`define LSCE_ST_REALIGN   4
`define LSCE_ST_ALIGN     3
`define LSCE_ST_SPLL      2
`define LSCE_ST_CPLL      0

// channel enable bit positions and reset
`define LSCE_CH_SINGLE    2
`define LSCE_CH_UPPER     1
`define LSCE_CH_LOWER     0
`define LSCE_CHAN_RST     3'h3

// control bits
`define LSCE_CTL_LINK     0
`define LSCE_CTL_CAL      1
`define LSCE_CTRL_RST     2'h0
`define LSCE_SYNCW_RST    2'h0

// geometry fields
`define LSCE_CNT_W        4
`define LSCE_GEOM_LHI     3
`define LSCE_GEOM_LLO     0
`define LSCE_GEOM_MHI     7
`define LSCE_GEOM_MLO     4

// bus encodings
`define LSCE_HSIZE_WORD   3'h2
`define LSCE_HRESP_OKAY   1'h0

`endif

// *** include/lsce_pkg.sv ***
package lsce_pkg;

    // one register access from the bus front end
    typedef struct packed {
        logic        wr;
        logic [9:0]  idx;
        logic [7:0]  wdata;
    } lsce_req_s;

    // frame geometry handed to the link framer
    typedef struct packed {
        logic [3:0]  lanes;
        logic [3:0]  convs;
        logic        tail_bits;
        logic        swap_pairs;
    } lsce_frame_s;

endpackage : lsce_pkg

// *** hw/lsce_sync.sv ***
`timescale 1ns/1ps

module lsce_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : lsce_sync

// *** hw/lsce_ahb_if.sv ***
`timescale 1ns/1ps
`include "lsce_defines.svh"

module lsce_ahb_if (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    input  wire logic [7:0]        rdata,
    output lsce_pkg::lsce_req_s    req,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp
);
    import lsce_pkg::*;

    logic                   accept;
    logic                   wr_pend_r;
    logic                   rd_pend_r;
    logic [`LSCE_IDX_W-1:0] idx_r;

    assign accept = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////////
    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            idx_r     <= `LSCE_IDX_NONE;
        end else if (accept) begin
            wr_pend_r <= hwrite && (hsize == `LSCE_HSIZE_WORD);
            rd_pend_r <= !hwrite;
            // addresses beyond the block fall onto an unmapped index
            if (haddr[`LSCE_ADDR_TOP:`LSCE_ADDR_TOPLO] != '0) begin
                idx_r <= `LSCE_IDX_NONE;
            end else begin
                idx_r <= haddr[`LSCE_IDX_HI:`LSCE_IDX_LO];
            end
        end else begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read takes one wait state so a write just before it is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata    <= '0;
            hresp     <= `LSCE_HRESP_OKAY;
        end else begin
            hresp <= `LSCE_HRESP_OKAY;
            if (accept && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend_r) begin
                hreadyout <= 1'b1;
                hrdata    <= {24'h0, rdata};
            end else begin
                hreadyout <= 1'b1;
            end
        end
    end

    always_comb begin
        req.wr    = wr_pend_r;
        req.idx   = idx_r;
        req.wdata = hwdata[7:0];
    end

endmodule : lsce_ahb_if

// *** hw/lsce_top.sv ***
`timescale 1ns/1ps
`include "lsce_defines.svh"

module lsce_top #(
    parameter logic [3:0] LANES_DEF = 4'h8,
    parameter logic [3:0] CONVS_DEF = 4'h4
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              link_up_in,
    input  wire logic              sync_n_pin,
    input  wire logic              serializer_pll_lock_pin,
    input  wire logic              sampling_pll_lock_pin,
    input  wire logic              sysref_event,
    input  wire logic              sysref_realign,
    output logic                   irq,
    output logic                   link_enable,
    output logic                   cal_enable,
    output logic [1:0]             sync_word_select,
    output logic [3:0]             chan_power,
    output logic                   one_channel_mode,
    output lsce_pkg::lsce_frame_s  frame_cfg
);
    import lsce_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // halve a count, optionally rounding up
    function automatic logic [`LSCE_CNT_W-1:0] lsce_half(
        input logic [`LSCE_CNT_W-1:0] val,
        input logic                   up
    );
        logic [`LSCE_CNT_W:0] sum;
        sum = {1'b0, val} + {{`LSCE_CNT_W{1'b0}}, up};
        return sum[`LSCE_CNT_W:1];
    endfunction : lsce_half

    // write strobe for one register index
    function automatic logic lsce_hit(
        input lsce_req_s              r,
        input logic [`LSCE_IDX_W-1:0] idx
    );
        return r.wr && (r.idx == idx);
    endfunction : lsce_hit

    ////////////////////////////////////////////////////////////////////////////
    // bus front end
    lsce_req_s  req;
    logic [7:0] rdata;

    lsce_ahb_if u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .rdata     (rdata),
        .req       (req),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin inputs from other domains
    logic [2:0] pins_sync;

    lsce_sync #(
        .WIDTH (3)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({sync_n_pin, serializer_pll_lock_pin, sampling_pll_lock_pin}),
        .sync_out (pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // live status bits
    logic link_up_r;
    logic sync_state_r;
    logic spll_lock_r;
    logic cpll_lock_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_up_r    <= 1'b0;
            sync_state_r <= 1'b0;
            spll_lock_r  <= 1'b0;
            cpll_lock_r  <= 1'b0;
        end else begin
            link_up_r    <= link_up_in;
            sync_state_r <= pins_sync[2];
            spll_lock_r  <= pins_sync[1];
            cpll_lock_r  <= pins_sync[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    logic       link_en_d_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (lsce_hit(req, `LSCE_IDX_CTRL)) begin
            ctrl_nxt = {req.wdata[`LSCE_CTL_CAL], req.wdata[`LSCE_CTL_LINK]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r      <= `LSCE_CTRL_RST;
            link_en_d_r <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            link_en_d_r <= ctrl_r[`LSCE_CTL_LINK];
        end
    end

    logic [1:0] syncw_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            syncw_r <= `LSCE_SYNCW_RST;
        end else if (lsce_hit(req, `LSCE_IDX_SYNCW)) begin
            syncw_r <= req.wdata[1:0];
        end
    end

    logic [2:0] chan_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_r <= `LSCE_CHAN_RST;
        end else if (lsce_hit(req, `LSCE_IDX_CHAN)) begin
            chan_r <= req.wdata[2:0];
        end
    end

    logic [3:0] lanes_cfg_r;
    logic [3:0] convs_cfg_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lanes_cfg_r <= LANES_DEF;
            convs_cfg_r <= CONVS_DEF;
        end else if (lsce_hit(req, `LSCE_IDX_GEOM)) begin
            lanes_cfg_r <= req.wdata[`LSCE_GEOM_LHI:`LSCE_GEOM_LLO];
            convs_cfg_r <= req.wdata[`LSCE_GEOM_MHI:`LSCE_GEOM_MLO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky alignment flags, a set in the clearing cycle wins
    logic armed_r;
    logic realign_r;
    logic multiframe_phase_set_r;
    logic st_wr;
    logic align_set;

    assign st_wr     = lsce_hit(req, `LSCE_IDX_STATUS);
    assign align_set = sysref_event && armed_r && ctrl_r[`LSCE_CTL_LINK];

    // armed from the rise of link enable until the first sysref
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_r <= 1'b0;
        end else if (!ctrl_r[`LSCE_CTL_LINK]) begin
            armed_r <= 1'b0;
        end else if (!link_en_d_r) begin
            armed_r <= 1'b1;
        end else if (sysref_event) begin
            armed_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            realign_r <= 1'b0;
        end else if (sysref_realign) begin
            realign_r <= 1'b1;
        end else if (st_wr && req.wdata[`LSCE_ST_REALIGN]) begin
            realign_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            multiframe_phase_set_r <= 1'b0;
        end else if (align_set) begin
            multiframe_phase_set_r <= 1'b1;
        end else if (st_wr && req.wdata[`LSCE_ST_ALIGN]) begin
            multiframe_phase_set_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt mask and level output
    logic [1:0] mask_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= 2'h0;
        end else if (lsce_hit(req, `LSCE_IDX_MASK)) begin
            mask_r <= {req.wdata[`LSCE_ST_REALIGN], req.wdata[`LSCE_ST_ALIGN]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |({realign_r, multiframe_phase_set_r} & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, reserved bits read zero
    logic [7:0] status_val;
    logic [7:0] mask_val;

    always_comb begin
        status_val                   = 8'h00;
        status_val[`LSCE_ST_LINK]    = link_up_r;
        status_val[`LSCE_ST_SYNC]    = sync_state_r;
        status_val[`LSCE_ST_REALIGN] = realign_r;
        status_val[`LSCE_ST_ALIGN]   = multiframe_phase_set_r;
        status_val[`LSCE_ST_SPLL]    = spll_lock_r;
        status_val[`LSCE_ST_CPLL]    = cpll_lock_r;
        mask_val                     = 8'h00;
        mask_val[`LSCE_ST_REALIGN]   = mask_r[1];
        mask_val[`LSCE_ST_ALIGN]     = mask_r[0];
    end

    always_comb begin
        case (req.idx)
            `LSCE_IDX_STATUS: rdata = status_val;
            `LSCE_IDX_CHAN:   rdata = {5'h00, chan_r};
            `LSCE_IDX_SYNCW:  rdata = {6'h00, syncw_r};
            `LSCE_IDX_MASK:   rdata = mask_val;
            `LSCE_IDX_CTRL:   rdata = {6'h00, ctrl_r};
            `LSCE_IDX_GEOM:   rdata = {convs_cfg_r, lanes_cfg_r};
            default:          rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel power and frame geometry
    logic        single;
    logic        lower_on;
    logic        upper_on;
    logic        halved;
    lsce_frame_s frame_nxt;
    logic [3:0]  power_nxt;

    assign single   = chan_r[`LSCE_CH_SINGLE];
    assign lower_on = chan_r[`LSCE_CH_LOWER];
    assign upper_on = chan_r[`LSCE_CH_UPPER] && !single;

    always_comb begin
        // channels D C B A from msb down
        power_nxt[0] = lower_on;
        power_nxt[1] = lower_on && !single;
        power_nxt[2] = upper_on;
        power_nxt[3] = upper_on;
        halved       = !(lower_on && upper_on);
        if (halved) begin
            frame_nxt.lanes = lsce_half(lanes_cfg_r, 1'b1);
            frame_nxt.convs = lsce_half(convs_cfg_r, 1'b0);
        end else begin
            frame_nxt.lanes = lanes_cfg_r;
            frame_nxt.convs = convs_cfg_r;
        end
        frame_nxt.tail_bits  = halved && lanes_cfg_r[0];
        frame_nxt.swap_pairs = !lower_on && upper_on;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_power       <= 4'hf;
            one_channel_mode <= 1'b0;
            frame_cfg        <= '{lanes: LANES_DEF, convs: CONVS_DEF,
                                  tail_bits: 1'b0, swap_pairs: 1'b0};
        end else begin
            chan_power       <= power_nxt;
            one_channel_mode <= single;
            frame_cfg        <= frame_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_enable      <= 1'b0;
            cal_enable       <= 1'b0;
            sync_word_select <= `LSCE_SYNCW_RST;
        end else begin
            link_enable      <= ctrl_r[`LSCE_CTL_LINK];
            cal_enable       <= ctrl_r[`LSCE_CTL_CAL];
            sync_word_select <= syncw_r;
        end
    end

endmodule : lsce_top

// *** verification/lsce_monitor.sv ***
`timescale 1ns/1ps

module lsce_monitor
    import lsce_pkg::*;
#(
    parameter logic [3:0] LANES_DEF = 4'h8,
    parameter logic [3:0] CONVS_DEF = 4'h4
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [3:0]  chan_power,
    input wire logic        one_channel_mode,
    input wire lsce_frame_s frame_cfg
);
    import lsce_pkg::*;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
        else $error("read data moved outside a read");
    a_single_power: assert property (one_channel_mode |-> chan_power[3:1] == 3'b000)
        else $error("single mode leaves other channels on");
    a_upper_pair: assert property (chan_power[3] == chan_power[2])
        else $error("upper pair split");
    a_lower_pair: assert property (!chan_power[0] |-> !chan_power[1])
        else $error("channel b on without lower pair");
    a_full_geom: assert property (chan_power == 4'hf
        |-> !frame_cfg.tail_bits && !frame_cfg.swap_pairs)
        else $error("full width frame altered");
    a_swap_place: assert property (frame_cfg.swap_pairs |-> chan_power == 4'hc)
        else $error("swap without lower pair off");
endmodule : lsce_monitor

bind lsce_top lsce_monitor #(
    .LANES_DEF(LANES_DEF),
    .CONVS_DEF(CONVS_DEF)
) lsce_monitor_i (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hready           (hready),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .chan_power       (chan_power),
    .one_channel_mode (one_channel_mode),
    .frame_cfg        (frame_cfg)
);

// *** verification/lsce_rx_model.sv ***
`timescale 1ns/1ps

module lsce_rx_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic link_enable,
    input  wire logic want_sync,
    input  wire logic pll_ok,
    input  wire logic fire_event,
    input  wire logic fire_realign,
    output logic      link_up_in,
    output logic      sync_n_pin,
    output logic      serializer_pll_lock_pin,
    output logic      sampling_pll_lock_pin,
    output logic      sysref_event,
    output logic      sysref_realign
);
    // receiver asks resync by pulling sync low; link drops meanwhile
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_n_pin <= 1'b0;
            link_up_in <= 1'b0;
        end else begin
            sync_n_pin <= !want_sync;
            link_up_in <= link_enable && !want_sync;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serializer_pll_lock_pin <= 1'b0;
            sampling_pll_lock_pin   <= 1'b0;
            sysref_event            <= 1'b0;
            sysref_realign          <= 1'b0;
        end else begin
            serializer_pll_lock_pin <= pll_ok;
            sampling_pll_lock_pin   <= pll_ok;
            sysref_event            <= fire_event;
            sysref_realign          <= fire_realign;
        end
    end
endmodule : lsce_rx_model

// *** verification/test_link_status_channel_enable.sv ***
`timescale 1ns/1ps
`include "lsce_defines.svh"

module test_link_status_channel_enable;
    import lsce_pkg::*;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, irq, link_enable, cal_enable, one_channel_mode;
    logic [1:0]  sync_word_select;
    logic [3:0]  chan_power;
    lsce_frame_s frame_cfg;
    logic        link_up_in, sync_n_pin, spll_lock, cpll_lock, sysref_event, sysref_realign;
    logic        want_sync = 1'b0;
    logic        pll_ok = 1'b1;
    logic        fire_event = 1'b0;
    logic        fire_realign = 1'b0;
    logic [31:0] seed_r = 32'hecb58399;
    logic [31:0] exp_q[$];
    logic        rd_dp = 1'b0;
    int          miscompares = 0;
    int          cmp_count = 0;

    assign hready = hreadyout;

    initial begin
        forever #2 hclk = ~hclk;
    end

    lsce_top lsce_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_up_in(link_up_in),
        .sync_n_pin(sync_n_pin), .serializer_pll_lock_pin(spll_lock),
        .sampling_pll_lock_pin(cpll_lock), .sysref_event(sysref_event),
        .sysref_realign(sysref_realign), .irq(irq), .link_enable(link_enable),
        .cal_enable(cal_enable), .sync_word_select(sync_word_select),
        .chan_power(chan_power), .one_channel_mode(one_channel_mode), .frame_cfg(frame_cfg));

    lsce_rx_model lsce_rx_model_i (.hclk(hclk), .hresetn(hresetn), .link_enable(link_enable),
        .want_sync(want_sync), .pll_ok(pll_ok), .fire_event(fire_event),
        .fire_realign(fire_realign), .link_up_in(link_up_in), .sync_n_pin(sync_n_pin),
        .serializer_pll_lock_pin(spll_lock), .sampling_pll_lock_pin(cpll_lock),
        .sysref_event(sysref_event), .sysref_realign(sysref_realign));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    function automatic logic [31:0] xs();
        seed_r = seed_r ^ (seed_r << 13);
        seed_r = seed_r ^ (seed_r >> 17);
        seed_r = seed_r ^ (seed_r << 5);
        return seed_r;
    endfunction : xs

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 64) begin
                miscompares++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= addr;
        hsize  <= `LSCE_HSIZE_WORD;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? data : 32'h0;
        wait_ready();
    endtask : ahb_xfer

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        ahb_xfer(1'b1, {20'h0, idx, 2'b00}, {xs() & 32'hffffff00} | {24'h0, d});
    endtask : wr

    task automatic rd(input logic [31:0] addr, input logic [7:0] exp);
        exp_q.push_back({24'h0, exp});
        ahb_xfer(1'b0, addr, 32'h0);
    endtask : rd

    task automatic pulse(input logic realign);
        @(posedge hclk);
        fire_event   <= !realign;
        fire_realign <= realign;
        @(posedge hclk);
        fire_event   <= 1'b0;
        fire_realign <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask : pulse

    // read data phase ends where hready is seen high again
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            check(hrdata, exp_q.pop_front());
            rd_dp = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1)
            rd_dp = 1'b1;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] ST = {20'h0, `LSCE_IDX_STATUS, 2'b00};
    localparam logic [31:0] CH = {20'h0, `LSCE_IDX_CHAN, 2'b00};
    logic [2:0]  modes[4] = '{3'h3, 3'h1, 3'h2, 3'h5};
    logic [31:0] r;
    logic [3:0]  lx, mx, ln, px;
    logic [2:0]  m;
    logic [9:0]  fx;
    logic        h;

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        check({28'h0, chan_power}, 32'hf);
        check({22'h0, frame_cfg}, {22'h0, 4'h8, 4'h4, 2'b00});
        rd(CH, 8'h03);
        repeat (6) @(posedge hclk);
        rd(ST, 8'h25);
        wr(`LSCE_IDX_STATUS, 8'hff);
        rd(ST, 8'h25);
        wr(`LSCE_IDX_CTRL, 8'h01);
        repeat (8) @(posedge hclk);
        rd(ST, 8'h65);
        pulse(1'b0);
        rd(ST, 8'h6d);
        wr(`LSCE_IDX_STATUS, 8'h00);
        rd(ST, 8'h6d);
        wr(`LSCE_IDX_STATUS, 8'h08);
        pulse(1'b0);
        rd(ST, 8'h65);
        @(posedge hclk);
        want_sync <= 1'b1;
        pll_ok    <= 1'b0;
        repeat (8) @(posedge hclk);
        rd(ST, 8'h00);
        want_sync <= 1'b0;
        pll_ok    <= 1'b1;
        wr(`LSCE_IDX_MASK, 8'h10);
        pulse(1'b1);
        check({31'h0, irq}, 32'h1);
        rd(ST, 8'h75);
        wr(`LSCE_IDX_MASK, 8'h00);
        repeat (3) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        wr(`LSCE_IDX_STATUS, 8'h10);
        rd(ST, 8'h65);
        wr(`LSCE_IDX_CTRL, 8'h00);
        repeat (8) @(posedge hclk);
        pulse(1'b0);
        rd(ST, 8'h25);
        for (int k = 0; k < 8; k++) begin
            r  = xs();
            lx = r[3:0] | {3'b0, ~|r[3:0]};
            mx = r[7:4] | {3'b0, ~|r[7:4]};
            wr(`LSCE_IDX_GEOM, {mx, lx});
            m  = modes[k % 4];
            wr(`LSCE_IDX_CHAN, {5'h0, m});
            repeat (4) @(posedge hclk);
            h  = !(m[0] && m[1] && !m[2]);
            ln = h ? (lx >> 1) + {3'b0, lx[0]} : lx;
            px = {{2{m[1] & !m[2]}}, m[0] & !m[2], m[0]};
            fx = {ln, h ? mx >> 1 : mx, h & lx[0], !m[0] & m[1] & !m[2]};
            check({31'h0, one_channel_mode}, {31'h0, m[2]});
            check({28'h0, chan_power}, {28'h0, px});
            check({22'h0, frame_cfg}, {22'h0, fx});
            rd(CH, {5'h0, m});
        end
        ahb_xfer(1'b1, 32'h1000 | CH, 32'h3);
        rd(32'h1000 | CH, 8'h00);
        rd(CH, 8'h05);
        wr(`LSCE_IDX_SYNCW, 8'h02);
        wr(`LSCE_IDX_CTRL, 8'h02);
        repeat (3) @(posedge hclk);
        check({30'h0, sync_word_select}, 32'h2);
        check({30'h0, cal_enable, link_enable}, 32'h2);
        repeat (3) @(posedge hclk);
        check(exp_q.size(), 32'h0);
        summarize();
    end
endmodule : test_link_status_channel_enable
